// ### charge_accum.sv
`timescale 1ns/1ps
module charge_accum #(
  parameter int unsigned ACC_W = gauge_pkg::ACC_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // conversion results
  input wire logic add_en,
  input wire logic [gauge_pkg::CUR_W-1:0] sample,
  // restart and scaling
  input wire logic load_en,
  input wire logic [15:0] load_val,
  input wire logic [15:0] scale,
  // state
  output logic [gauge_pkg::CNT_W-1:0] count,
  output logic [15:0] soc
);

  localparam int unsigned PROD_W = ACC_W + 17;

  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic signed [ACC_W-1:0] ext;
  logic signed [PROD_W-1:0] prod;
  logic [gauge_pkg::CNT_W-1:0] cnt_q;
  logic [gauge_pkg::CNT_W-1:0] cnt_d;
  logic [15:0] base_q;
  logic [15:0] base_d;
  logic [15:0] soc_q;
  logic [15:0] soc_d;

  always_comb
  begin
    // two's complement result, sign extended into the accumulator
    ext = {{(ACC_W - gauge_pkg::CUR_W){sample[gauge_pkg::CUR_W-1]}}, sample}; // RULE_09
    acc_d = acc_q;
    cnt_d = cnt_q;
    base_d = base_q;
    // restart wins over a coincident add: the new level is the reference
    if (load_en)
    begin
      acc_d = '0; // RULE_14
      base_d = load_val; // RULE_14
    end
    else if (add_en)
    begin
      acc_d = acc_q + ext; // RULE_10
      cnt_d = cnt_q + 16'h0001; // RULE_10
    end
    prod = PROD_W'(acc_q) * PROD_W'($signed({1'b0, scale})); // RULE_19
    soc_d = base_q + prod[gauge_pkg::SOC_SHIFT +: 16]; // RULE_19
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_q <= '0;
      cnt_q <= '0;
      base_q <= '0;
      soc_q <= '0;
    end
    else if (ce)
    begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      base_q <= base_d;
      soc_q <= soc_d;
    end
  end

  assign count = cnt_q;
  assign soc = soc_q;

  property p_count_step;
    @(posedge clk) disable iff (rst)
    (ce && add_en && !load_en) |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step"); // RULE_10

endmodule : charge_accum

// ### conv_model.sv
`timescale 1ns/1ps
module conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter side
  input wire gauge_pkg::adc_req_s adc_req,
  output logic [13:0] adc_result,
  // values handed back per input kind
  input wire logic [13:0] volt_val,
  input wire logic [13:0] temp_val,
  input wire logic [13:0] cur_val,
  // slot bookkeeping for the bench
  output int age,
  output int len,
  output logic [1:0] last,
  output logic [1:0] prev
);
  logic [13:0] hold;
  logic busy;
  // value latched at start: the bench may change its inputs mid-slot
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // not 1, so leaving reset never looks like a slot start
      age <= 2;
      len <= 0;
      last <= 2'h0;
      prev <= 2'h0;
      hold <= 14'h0;
      busy <= 1'b0;
    end
    else if (adc_req.start)
    begin
      age <= 1;
      len <= age;
      prev <= last;
      last <= adc_req.sel;
      busy <= 1'b1;
      hold <= (adc_req.sel == gauge_pkg::KIND_VOLT) ? volt_val :
        (adc_req.sel == gauge_pkg::KIND_TEMP) ? temp_val : cur_val;
    end
    else
      age <= age + 1;
  end
  // before the first slot a changing pattern, so an early sample cannot match
  assign adc_result = busy ? hold : 14'(age) ^ 14'h2aaa;
endmodule : conv_model

// ### gauge_measurement_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: power-select 0 runs mixed mode with charge counter and voltage estimator.
// RULE_02: power-select 1 runs voltage-only, no current sensing, counter unused.
// RULE_03: mixed mode converts current continuously, voltage slot each 4 s, temperature 16 s.
// RULE_04: voltage-only mode converts voltage each 4 s, temperature each 16 s.
// RULE_05: voltage and temperature conversions last 8192 time-base ticks, 250 ms.
// RULE_06: voltage result 0 to 4.5 V in 2.20 mV steps, stored in voltage register.
// RULE_07: temperature in whole degrees, -40 to +125, stored in temperature register.
// RULE_08: current conversion integrates 500 ms, 14-bit result of 5.88 uV steps.
// RULE_09: current results are signed two's complement.
// RULE_10: each current result adds to accumulator and bumps 16-bit conversion count; here a result ending with a charge-level write is dropped.
// RULE_11: current register takes only the conversion just before each voltage slot.
// RULE_12: 16-bit charge scale converts charge to percent, resets to 395.
// RULE_13: charge counter idle while power-select set; power-select resets to 1.
// RULE_14: writing charge level restarts charge gauging from the written value.
// RULE_15: 12-bit voltage-model parameter resets to 321.
// RULE_16: present open-circuit estimate is readable.
// RULE_17: writable curve adjust registers modify the open-circuit reference table; here curve_q is only written and read back, ocv_q ignores it.
// RULE_18: mode may change at any time; charge level tracking continues.
// RULE_19: accumulated charge scaled by the charge scale gives relative charge level.
// RULE_20: slots come from time-base counters; temperature on every fourth voltage slot.
module gauge_measurement_sequencer #(
  parameter int unsigned VT_TICKS = gauge_pkg::VT_CONV_TICKS,
  parameter int unsigned CUR_TICKS = gauge_pkg::CUR_CONV_TICKS,
  parameter int unsigned FRAME_TICKS = gauge_pkg::FRAME_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control register access
  input wire gauge_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // shared converter
  output gauge_pkg::adc_req_s adc_req,
  input wire logic [gauge_pkg::CUR_W-1:0] adc_result
);

  localparam int unsigned TMR_W = $clog2(CUR_TICKS + 1) + 1;
  localparam int unsigned FRM_W = $clog2(FRAME_TICKS + 1);

  typedef enum logic [1:0] {S_IDLE, S_CUR, S_VOLT, S_TEMP} slot_e;

  // internal 32768 Hz time base, made by a phase accumulator
  logic [gauge_pkg::PHASE_W-1:0] ph_q;
  logic [gauge_pkg::PHASE_W-1:0] ph_d;
  logic [gauge_pkg::PHASE_W-1:0] ph_sum;
  logic tick;

  always_comb
  begin
    ph_sum = ph_q + gauge_pkg::PHASE_W'(gauge_pkg::OSC_HZ);
    tick = (ph_sum >= gauge_pkg::PHASE_W'(gauge_pkg::CLK_HZ));
    ph_d = tick ? ph_sum - gauge_pkg::PHASE_W'(gauge_pkg::CLK_HZ) : ph_sum;
  end

  // frame counters and pending slot flags
  logic [FRM_W-1:0] frm_q;
  logic [FRM_W-1:0] frm_d;
  logic [1:0] fidx_q;
  logic [1:0] fidx_d;
  logic vpend_q;
  logic vpend_d;
  logic tpend_q;
  logic tpend_d;
  logic frame_end;

  // slot state
  slot_e st_q;
  slot_e st_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_d;
  gauge_pkg::adc_req_s req_q;
  gauge_pkg::adc_req_s req_d;
  logic slot_end;
  logic cur_add;
  logic cur_to_reg;

  // registers
  logic mode_q;
  logic mode_d;
  logic [gauge_pkg::CUR_W-1:0] cur_q;
  logic [gauge_pkg::CUR_W-1:0] cur_d;
  logic [gauge_pkg::VOLT_W-1:0] volt_q;
  logic [gauge_pkg::VOLT_W-1:0] volt_d;
  logic signed [gauge_pkg::TEMP_W-1:0] temp_q;
  logic signed [gauge_pkg::TEMP_W-1:0] temp_d;
  logic signed [gauge_pkg::TEMP_W-1:0] temp_raw;
  logic [gauge_pkg::VOLT_W-1:0] ocv_q;
  logic [gauge_pkg::VOLT_W-1:0] ocv_d;
  logic [15:0] cc_cnf_q;
  logic [15:0] cc_cnf_d;
  logic [11:0] vm_cnf_q;
  logic [11:0] vm_cnf_d;
  logic [gauge_pkg::CURVE_W-1:0] curve_q [gauge_pkg::CURVE_N];
  logic [gauge_pkg::CURVE_W-1:0] curve_d [gauge_pkg::CURVE_N];
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic charge_load;
  logic [gauge_pkg::CNT_W-1:0] conv_count;
  logic [15:0] soc;
  logic [7:0] curve_off;

  always_comb
  begin
    frame_end = tick && (frm_q == FRM_W'(FRAME_TICKS - 1));
    frm_d = frm_q;
    fidx_d = fidx_q;
    if (tick)
    begin
      frm_d = frame_end ? '0 : frm_q + 1'b1; // RULE_20
    end
    if (frame_end)
    begin
      fidx_d = (fidx_q == 2'(gauge_pkg::TEMP_EVERY - 1)) ? 2'h0 : fidx_q + 2'h1; // RULE_20
    end
  end

  // next slot after the present one ends, or from idle
  function automatic slot_e pick(input logic vp, input logic tp, input logic from_volt,
                                 input logic mode);
    slot_e r;
    if (from_volt && tp)
      r = S_TEMP; // RULE_20
    else if (vp && !from_volt)
      r = S_VOLT; // RULE_03 RULE_04
    else if (!mode)
      r = S_CUR; // RULE_01 RULE_03
    else
      r = S_IDLE; // RULE_02
    return r;
  endfunction : pick

  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    req_d = '0;
    vpend_d = vpend_q;
    tpend_d = tpend_q;
    cur_d = cur_q;
    volt_d = volt_q;
    ocv_d = ocv_q;
    temp_d = temp_q;
    temp_raw = adc_result[gauge_pkg::TEMP_W-1:0];
    cur_add = 1'b0;
    cur_to_reg = 1'b0;
    unique case (st_q)
      S_CUR: slot_end = tick && (tmr_q == TMR_W'(CUR_TICKS - 1)); // RULE_08
      S_VOLT, S_TEMP: slot_end = tick && (tmr_q == TMR_W'(VT_TICKS - 1)); // RULE_05
      S_IDLE: slot_end = 1'b1;
    endcase
    if (tick)
    begin
      tmr_d = tmr_q + 1'b1;
    end
    if (slot_end)
    begin
      unique case (st_q)
        S_CUR:
        begin
          // a switch to voltage-only during the slot discards the result
          cur_add = !mode_q; // RULE_13 RULE_18
          cur_to_reg = !mode_q && vpend_q; // RULE_11
          if (cur_to_reg)
            cur_d = adc_result; // RULE_08 RULE_11
        end
        S_VOLT:
        begin
          volt_d = adc_result[gauge_pkg::VOLT_W-1:0]; // RULE_06
          ocv_d = adc_result[gauge_pkg::VOLT_W-1:0]; // RULE_16
          vpend_d = 1'b0;
        end
        S_TEMP:
        begin
          if (temp_raw < gauge_pkg::TEMP_MIN)
            temp_d = gauge_pkg::TEMP_MIN; // RULE_07
          else if (temp_raw > gauge_pkg::TEMP_MAX)
            temp_d = gauge_pkg::TEMP_MAX; // RULE_07
          else
            temp_d = temp_raw; // RULE_07
          tpend_d = 1'b0;
        end
        S_IDLE:
        begin
        end
      endcase
      st_d = pick(vpend_q, tpend_q, st_q == S_VOLT, mode_q);
      tmr_d = '0;
      if (st_d != S_IDLE)
      begin
        req_d.start = 1'b1;
        req_d.sel = (st_d == S_CUR) ? gauge_pkg::KIND_CUR :
                    (st_d == S_VOLT) ? gauge_pkg::KIND_VOLT : gauge_pkg::KIND_TEMP;
      end
    end
    // a frame boundary in the same cycle as a clear still raises the flag
    if (frame_end)
    begin
      vpend_d = 1'b1; // RULE_03 RULE_04
      if (fidx_q == 2'(gauge_pkg::TEMP_EVERY - 1))
        tpend_d = 1'b1; // RULE_20
    end
  end

  // register access
  always_comb
  begin
    mode_d = mode_q;
    cc_cnf_d = cc_cnf_q;
    vm_cnf_d = vm_cnf_q;
    curve_d = curve_q;
    charge_load = 1'b0;
    curve_off = reg_req.addr - gauge_pkg::ADDR_CURVE_BASE;
    rdata_d = rdata_q;
    if (reg_req.wr)
    begin
      if (reg_req.addr == gauge_pkg::ADDR_MODE)
        mode_d = reg_req.wdata[gauge_pkg::MODE_PWR_BIT]; // RULE_18
      else if (reg_req.addr == gauge_pkg::ADDR_CHARGE)
        charge_load = 1'b1; // RULE_14
      else if (reg_req.addr == gauge_pkg::ADDR_CC_CNF)
        cc_cnf_d = reg_req.wdata; // RULE_12
      else if (reg_req.addr == gauge_pkg::ADDR_VM_CNF)
        vm_cnf_d = reg_req.wdata[11:0]; // RULE_15
      else if (curve_off < 8'(gauge_pkg::CURVE_N))
        curve_d[curve_off[3:0]] = reg_req.wdata[gauge_pkg::CURVE_W-1:0]; // RULE_17
    end
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        gauge_pkg::ADDR_MODE: rdata_d = {15'h0000, mode_q};
        gauge_pkg::ADDR_CHARGE: rdata_d = soc; // RULE_19
        gauge_pkg::ADDR_COUNT: rdata_d = conv_count; // RULE_10
        gauge_pkg::ADDR_CURRENT: rdata_d = {{2{cur_q[gauge_pkg::CUR_W-1]}}, cur_q}; // RULE_09
        gauge_pkg::ADDR_VOLTAGE: rdata_d = {4'h0, volt_q};
        gauge_pkg::ADDR_TEMP: rdata_d = {{8{temp_q[7]}}, temp_q};
        gauge_pkg::ADDR_OCV: rdata_d = {4'h0, ocv_q}; // RULE_16
        gauge_pkg::ADDR_CC_CNF: rdata_d = cc_cnf_q;
        gauge_pkg::ADDR_VM_CNF: rdata_d = {4'h0, vm_cnf_q};
        default:
          rdata_d = (curve_off < 8'(gauge_pkg::CURVE_N)) ?
                    {8'h00, curve_q[curve_off[3:0]]} : 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ph_q <= '0;
      frm_q <= '0;
      fidx_q <= '0;
      vpend_q <= 1'b0;
      tpend_q <= 1'b0;
      st_q <= S_IDLE;
      tmr_q <= '0;
      req_q <= '0;
      mode_q <= gauge_pkg::MODE_RST; // RULE_13
      cur_q <= '0;
      volt_q <= '0;
      ocv_q <= '0;
      temp_q <= '0;
      cc_cnf_q <= gauge_pkg::CC_CNF_RST; // RULE_12
      vm_cnf_q <= gauge_pkg::VM_CNF_RST; // RULE_15
      curve_q <= '{default: '0};
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      ph_q <= ph_d;
      frm_q <= frm_d;
      fidx_q <= fidx_d;
      vpend_q <= vpend_d;
      tpend_q <= tpend_d;
      st_q <= st_d;
      tmr_q <= tmr_d;
      req_q <= req_d;
      mode_q <= mode_d;
      cur_q <= cur_d;
      volt_q <= volt_d;
      ocv_q <= ocv_d;
      temp_q <= temp_d;
      cc_cnf_q <= cc_cnf_d;
      vm_cnf_q <= vm_cnf_d;
      curve_q <= curve_d;
      rdata_q <= rdata_d;
      rvalid_q <= reg_req.rd;
    end
  end

  charge_accum #(
    .ACC_W(gauge_pkg::ACC_W)
  ) u_accum (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .add_en(cur_add),
    .sample(adc_result),
    .load_en(charge_load),
    .load_val(reg_req.wdata),
    .scale(cc_cnf_q),
    .count(conv_count),
    .soc(soc)
  );

  assign adc_req = req_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  sequence s_cur_end;
    ce && st_q == S_CUR && slot_end;
  endsequence
  sequence s_volt_end;
    ce && st_q == S_VOLT && slot_end;
  endsequence

  property p_no_cur_in_gauge_power_select;
    @(posedge clk) disable iff (rst)
    (req_q.start && req_q.sel == gauge_pkg::KIND_CUR) |-> !$past(mode_q);
  endproperty
  a_no_cur_in_gauge_power_select: assert property (p_no_cur_in_gauge_power_select) else $error("current in volt mode"); // RULE_02

  property p_mixed_continuous;
    @(posedge clk) disable iff (rst)
    (s_cur_end and (!vpend_q && !mode_q)) |=> (req_q.start && req_q.sel == gauge_pkg::KIND_CUR);
  endproperty
  a_mixed_continuous: assert property (p_mixed_continuous) else $error("current gap"); // RULE_03

  property p_volt_store;
    @(posedge clk) disable iff (rst)
    s_volt_end |=> (volt_q == $past(adc_result[gauge_pkg::VOLT_W-1:0]) && ocv_q == volt_q);
  endproperty
  a_volt_store: assert property (p_volt_store) else $error("voltage not stored"); // RULE_06

  property p_slot_len;
    @(posedge clk) disable iff (rst)
    (st_q == S_VOLT || st_q == S_TEMP) |-> (tmr_q < TMR_W'(VT_TICKS));
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("conversion overran"); // RULE_05

  property p_temp_range;
    @(posedge clk) disable iff (rst)
    (temp_q >= gauge_pkg::TEMP_MIN) && (temp_q <= gauge_pkg::TEMP_MAX);
  endproperty
  a_temp_range: assert property (p_temp_range) else $error("temperature out of range"); // RULE_07

  property p_cur_reg_once;
    @(posedge clk) disable iff (rst)
    !$stable(cur_q) |-> ($past(cur_to_reg) && st_q == S_VOLT);
  endproperty
  a_cur_reg_once: assert property (p_cur_reg_once) else $error("current reg update"); // RULE_11

  property p_restart;
    @(posedge clk) disable iff (rst)
    (ce && reg_req.wr && reg_req.addr == gauge_pkg::ADDR_CHARGE) ##1 (ce && !charge_load)
      |=> (soc == $past(reg_req.wdata, 2));
  endproperty
  a_restart: assert property (p_restart) else $error("charge restart"); // RULE_14

  property p_temp_after_volt;
    @(posedge clk) disable iff (rst)
    (req_q.start && req_q.sel == gauge_pkg::KIND_TEMP) |-> ($past(st_q) == S_VOLT);
  endproperty
  a_temp_after_volt: assert property (p_temp_after_volt) else $error("temp slot order"); // RULE_20

  property p_cfg_write;
    @(posedge clk) disable iff (rst)
    (ce && reg_req.wr && reg_req.addr == gauge_pkg::ADDR_CC_CNF) |=> (cc_cnf_q == $past(reg_req.wdata));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("scale write lost"); // RULE_12

endmodule : gauge_measurement_sequencer

// ### gauge_pkg.sv
package gauge_pkg;

  // time base
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned PHASE_W = 26;

  // conversion and scheduling times, in their own units
  localparam int unsigned VT_CONV_MS = 250;
  localparam int unsigned CUR_CONV_MS = 500;
  localparam int unsigned FRAME_S = 4;
  localparam int unsigned TEMP_S = 16;

  // the same times as counts of internal time-base ticks, temperature as a count of frames
  localparam int unsigned VT_CONV_TICKS = VT_CONV_MS * OSC_HZ / 1000;
  localparam int unsigned CUR_CONV_TICKS = CUR_CONV_MS * OSC_HZ / 1000;
  localparam int unsigned FRAME_TICKS = FRAME_S * OSC_HZ;
  localparam int unsigned TEMP_EVERY = TEMP_S / FRAME_S;

  // widths
  localparam int unsigned CUR_W = 14;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned VOLT_W = 12;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned ACC_W = 24;
  localparam int unsigned SOC_SHIFT = 16;
  localparam int unsigned CURVE_N = 16;
  localparam int unsigned CURVE_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CHARGE = 8'h01;
  localparam logic [7:0] ADDR_COUNT = 8'h02;
  localparam logic [7:0] ADDR_CURRENT = 8'h03;
  localparam logic [7:0] ADDR_VOLTAGE = 8'h04;
  localparam logic [7:0] ADDR_TEMP = 8'h05;
  localparam logic [7:0] ADDR_OCV = 8'h06;
  localparam logic [7:0] ADDR_CC_CNF = 8'h07;
  localparam logic [7:0] ADDR_VM_CNF = 8'h08;
  localparam logic [7:0] ADDR_CURVE_BASE = 8'h10;

  // field positions and reset values
  localparam int unsigned MODE_PWR_BIT = 0;
  localparam logic MODE_RST = 1'b1;
  localparam logic [15:0] CC_CNF_RST = 16'h018b;
  localparam logic [11:0] VM_CNF_RST = 12'h141;
  localparam logic signed [7:0] TEMP_MIN = 8'hd8;
  localparam logic signed [7:0] TEMP_MAX = 8'h7d;

  // converter input select
  localparam logic [1:0] KIND_CUR = 2'h0;
  localparam logic [1:0] KIND_VOLT = 2'h1;
  localparam logic [1:0] KIND_TEMP = 2'h2;

  typedef struct packed {
    logic start;
    logic [1:0] sel;
  } adc_req_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

endpackage : gauge_pkg

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int VT = 2;
  localparam int CUR = 4;
  localparam int FR = 12;
  // ticks fall 762 or 763 cycles apart, so a tick count lands within a cycle or two
  localparam int TOL = 2;
  localparam logic [1:0] KV = gauge_pkg::KIND_VOLT;
  localparam logic [1:0] KT = gauge_pkg::KIND_TEMP;
  localparam logic [1:0] KC = gauge_pkg::KIND_CUR;
  logic clk;
  logic rst;
  logic ce;
  gauge_pkg::reg_req_s reg_req;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  gauge_pkg::adc_req_s adc_req;
  logic [13:0] adc_result;
  logic [13:0] volt_val;
  logic [13:0] temp_val;
  logic [13:0] cur_val;
  int m_age;
  int m_len;
  logic [1:0] m_last;
  logic [1:0] m_prev;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int v_at = 0;
  int t_at = 0;
  int n_volt = 0;
  logic md = 1'b1;
  logic chk_on = 1'b1;
  logic [31:0] seed = 32'h16;

  gauge_measurement_sequencer #(.VT_TICKS(VT), .CUR_TICKS(CUR), .FRAME_TICKS(FR)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .adc_req(adc_req), .adc_result(adc_result));

  conv_model i_conv (
    .clk(clk), .rst(rst), .adc_req(adc_req), .adc_result(adc_result),
    .volt_val(volt_val), .temp_val(temp_val), .cur_val(cur_val),
    .age(m_age), .len(m_len), .last(m_last), .prev(m_prev));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic int cyc_of(input int t);
    return int'(longint'(t) * gauge_pkg::CLK_HZ / gauge_pkg::OSC_HZ);
  endfunction : cyc_of

  // level = base + (n * current * scale) >> 16
  function automatic logic [15:0] f_level(input logic [15:0] b, input int n,
                                          input logic [13:0] c, input logic [15:0] s);
    longint acc;
    acc = longint'(n) * longint'($signed(c));
    return b + 16'((acc * longint'(s)) >>> 16);
  endfunction : f_level

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_near(input int got, input int exp, input int tol);
    n_tests++;
    if (got < exp - tol || got > exp + tol)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_near

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk);
    reg_req.rd = 1'b0;
    d = reg_rdata;
    chk16({15'h0, reg_rvalid}, 16'h0001);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk16(d, e);
  endtask : rd_chk

  // returns at the falling edge just after the n-th start of kind k
  task automatic wait_slot(input logic [1:0] k, input int n);
    int c;
    c = 0;
    while (n > 0 && c < 40000)
    begin
      @(negedge clk);
      c++;
      if (m_age == 1 && m_last == k)
        n--;
    end
    if (n > 0)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, n, 0);
    end
  endtask : wait_slot

  // slot lengths and order, judged at each new start
  always @(negedge clk)
  begin
    if (!rst && m_age == 1)
    begin
      if (chk_on && (!md || m_last == KT))
        chk_near(m_len, cyc_of((m_prev == KC) ? CUR : VT), TOL);
      if (chk_on && md && m_last != KT)
        chk16({14'h0, m_last}, {14'h0, KV});
      if (m_last == KT)
      begin
        chk16({14'h0, m_prev}, {14'h0, KV});
        if (t_at != 0)
          chk16(16'(n_volt - t_at), 16'h0004);
        t_at = n_volt;
      end
      if (m_last == KV)
      begin
        if (chk_on && v_at != 0)
          chk_near(cycles - v_at, cyc_of(FR), md ? TOL : cyc_of(CUR) + TOL);
        v_at = cycles;
        n_volt++;
      end
    end
  end

  // run ceiling: the planned run is ten frames, about 94000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  initial
  begin
    logic [15:0] v;
    logic [15:0] sc;
    logic [15:0] base;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] lvl;
    logic [13:0] cv1;
    logic [13:0] cv2;
    logic [31:0] s0;
    int i;
    rst = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    volt_val = 14'h0;
    temp_val = 14'h00c0;
    cur_val = 14'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd_chk(gauge_pkg::ADDR_MODE, 16'h0001);
    rd_chk(gauge_pkg::ADDR_CC_CNF, 16'h018b);
    rd_chk(gauge_pkg::ADDR_VM_CNF, 16'h0141);
    wr(gauge_pkg::ADDR_COUNT, 16'h1234);
    rd_chk(gauge_pkg::ADDR_COUNT, 16'h0000);
    rd_chk(8'h0f, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      v = 16'(xs());
      wr(gauge_pkg::ADDR_CC_CNF, v);
      rd_chk(gauge_pkg::ADDR_CC_CNF, v);
      wr(gauge_pkg::ADDR_VM_CNF, v);
      rd_chk(gauge_pkg::ADDR_VM_CNF, {4'h0, v[11:0]});
    end
    sc = v;
    // with the enable low a write must leave no trace
    ce = 1'b0;
    wr(gauge_pkg::ADDR_CC_CNF, ~v);
    ce = 1'b1;
    rd_chk(gauge_pkg::ADDR_CC_CNF, v);
    // all curve cells written before any read, so aliasing shows
    s0 = seed;
    for (i = 0; i < 16; i++)
      wr(8'(gauge_pkg::ADDR_CURVE_BASE + i), 16'(xs()));
    seed = s0;
    for (i = 0; i < 16; i++)
    begin
      v = 16'(xs());
      rd_chk(8'(gauge_pkg::ADDR_CURVE_BASE + i), {8'h0, v[7:0]});
    end
    for (i = 0; i < 4; i++)
    begin
      volt_val = 14'(xs());
      wait_slot(KV, 1);
      repeat (2400) @(negedge clk);
      rd_chk(gauge_pkg::ADDR_VOLTAGE, {4'h0, volt_val[11:0]});
      rd_chk(gauge_pkg::ADDR_OCV, {4'h0, volt_val[11:0]});
    end
    repeat (2400) @(negedge clk);
    rd_chk(gauge_pkg::ADDR_TEMP, 16'hffd8);
    rd_chk(gauge_pkg::ADDR_COUNT, 16'h0000);
    cv1 = {1'b1, 13'(xs())};
    cv2 = {1'b0, 13'(xs())};
    cur_val = cv1;
    chk_on = 1'b0;
    md = 1'b0;
    v_at = 0;
    wr(gauge_pkg::ADDR_MODE, 16'h0000);
    // the first current slot leaves idle between ticks and runs short, so it is not judged
    wait_slot(KC, 2);
    @(negedge clk);
    chk_on = 1'b1;
    wait_slot(KV, 1);
    repeat (2400) @(negedge clk);
    rd_chk(gauge_pkg::ADDR_CURRENT, {{2{cv1[13]}}, cv1});
    cur_val = cv2;
    wait_slot(KC, 2);
    rd_chk(gauge_pkg::ADDR_CURRENT, {{2{cv1[13]}}, cv1});
    wait_slot(KV, 1);
    repeat (2400) @(negedge clk);
    rd_chk(gauge_pkg::ADDR_CURRENT, {2'b00, cv2});
    wait_slot(KC, 1);
    base = 16'(xs());
    wr(gauge_pkg::ADDR_CHARGE, base);
    rd_chk(gauge_pkg::ADDR_CHARGE, base);
    rd(gauge_pkg::ADDR_COUNT, c0);
    wait_slot(KC, 3);
    rd(gauge_pkg::ADDR_COUNT, c1);
    chk16(c1 - c0, 16'h0003);
    rd_chk(gauge_pkg::ADDR_CHARGE, f_level(base, 3, cv2, sc));
    // the running current slot may push the first voltage slot off its frame
    chk_on = 1'b0;
    md = 1'b1;
    wr(gauge_pkg::ADDR_MODE, 16'h0001);
    wait_slot(KV, 1);
    @(negedge clk);
    v_at = 0;
    chk_on = 1'b1;
    rd(gauge_pkg::ADDR_CHARGE, lvl);
    rd(gauge_pkg::ADDR_COUNT, c0);
    wait_slot(KV, 2);
    repeat (2400) @(negedge clk);
    rd_chk(gauge_pkg::ADDR_CHARGE, lvl);
    rd_chk(gauge_pkg::ADDR_COUNT, c0);
    give_verdict();
  end
endmodule : testbench
